/* logic/phy_shadow_pkg.sv */
package phy_shadow_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register addresses
    localparam logic [4:0] ADDR_SHADOW = 5'h18;
    localparam logic [4:0] ADDR_STATUS = 5'h19;

    // shadow value codes
    localparam logic [2:0] SHADOW_AUX     = 3'h0;
    localparam logic [2:0] SHADOW_TENBT   = 3'h1;
    localparam logic [2:0] SHADOW_POWER   = 3'h2;
    localparam logic [2:0] SHADOW_TEST    = 3'h4;
    localparam logic [2:0] SHADOW_CONTROL = 3'h7;

    // test shadow fields
    localparam int TST_LOOP      = 15;
    localparam int TST_LOOP_TRI  = 11;
    localparam int TST_SAME_PAIR = 4;
    localparam int TST_HALF_AMP  = 3;
    localparam logic [15:0] TST_RESET = 16'h4004;
    // writable bits (upper 13); select bits always read back the own code
    localparam logic [15:0] TST_WMASK = 16'hfff8;

    // control shadow fields
    localparam int CTL_WEN      = 15;
    localparam int CTL_RSEL_LO  = 12;
    localparam int CTL_PKT_RX   = 11;
    localparam int CTL_MDIX     = 9;
    localparam int CTL_SKEW     = 8;
    localparam logic [15:0] CTL_RESET    = 16'h01e7;
    localparam logic [15:0] CTL_ALWAYS_W = 16'h7000;
    localparam logic [15:0] CTL_GATED_W  = 16'h0ff8;

    // status summary fields
    localparam int ST_DONE  = 15;
    localparam int ST_MODE  = 8;
    localparam int ST_PDF   = 7;
    localparam int ST_RFLT  = 6;
    localparam int ST_PAGE  = 5;
    localparam int ST_LPAN  = 4;
    localparam int ST_LPNP  = 3;
    localparam int ST_LINK  = 2;
    localparam int ST_PRX   = 1;
    localparam int ST_PTX   = 0;
    localparam logic [2:0] MODE_NONE = 3'h0;
endpackage

/* logic/latch_high_flag.sv */
`timescale 1ns/1ps
// sticky flag set by an event, cleared by a read; set beats clear
module latch_high_flag (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic event_in,
    input  wire logic clear,
    output logic      flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (clear) begin
            next_flag = 1'b0;
        end
        if (event_in) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // latch_high_flag

/* logic/phy_shadow_regs.sv */
// Our own choice: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// - test bit 15 enables lineside loopback
// - loopback tristate floats receive MAC pins
// - test bit 4 puts rx/tx on one pair
// - test bit 3 halves 10M amplitude
// - write low bits choose target shadow
// - select field reads own shadow code
// - control bits 11:3 need write enable
// - control 14:12 and 2:0 always written
// - read selector picks 18h read shadow
// - control bit 11 selects packet count direction
// - control bit 9 forces crossover without negotiation
// - control bit 8 enables receive data skew
// - status bit 15 shows negotiation complete
// - bits 14:11 latch negotiation state entries
// - bits 10:8 encode resolved common mode
// - bit 7 latches parallel detection fault
// - bit 6 shows partner remote fault
// - bit 5 latches new page received
// - bit 4 shows partner negotiation ability
// - bit 3 shows partner next page ability
// - bit 2 shows link pass state
// - bit 1 gives receive pause resolution
// - negotiation off reports manual mode
// - bit 0 gives transmit pause resolution
module phy_shadow_regs #(
    parameter int ADDR_W = phy_shadow_pkg::ADDR_W,
    parameter int DATA_W = phy_shadow_pkg::DATA_W
) (
    input  wire logic              clock,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    // negotiation status, from the line side (other domain)
    input  wire logic              an_enable,
    input  wire logic              an_complete,
    input  wire logic              ev_link_good_check,
    input  wire logic              ev_ack_detect,
    input  wire logic              ev_ability_detect,
    input  wire logic              ev_next_page_wait,
    input  wire logic              ev_parallel_fault,
    input  wire logic              ev_page_received,
    input  wire logic [2:0]        resolved_common_mode,
    input  wire logic [2:0]        manual_mode,
    input  wire logic              partner_remote_fault,
    input  wire logic              partner_an_able,
    input  wire logic              partner_next_page,
    input  wire logic              link_pass,
    input  wire logic              pause_rx,
    input  wire logic              pause_tx,
    // controls to the data path and analog front end
    output logic                   lineside_loopback,
    output logic                   rx_mac_tristate,
    output logic                   same_pair_test,
    output logic                   half_amplitude_tx,
    output logic                   count_rx_packets,
    output logic                   force_auto_mdix,
    output logic                   auto_mdix_run,
    output logic                   rx_skew_enable,
    // other shadows of 18h live elsewhere; this strobe hands them their write
    output logic                   other_shadow_wr,
    output logic      [2:0]        read_shadow
);
    // decode and field layout below are fixed to this word shape
    if (ADDR_W != 5 || DATA_W != 16) begin : g_bad_width
        $error("phy_shadow_regs supports only 5-bit address and 16-bit data");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: every status pin crosses from the line clock
    localparam int NSYNC = 20;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] raw_in;

    assign raw_in = {an_enable, an_complete, ev_link_good_check, ev_ack_detect,
                     ev_ability_detect, ev_next_page_wait, ev_parallel_fault,
                     ev_page_received, resolved_common_mode, manual_mode,
                     partner_remote_fault, partner_an_able, partner_next_page,
                     link_pass, pause_rx, pause_tx};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic       s_an_en;
    logic       s_done;
    logic [3:0] s_state_lvl;
    logic       s_pdf;
    logic       s_page;
    logic [2:0] s_resolved;
    logic [2:0] s_manual;
    logic       s_rflt;
    logic       s_lpan;
    logic       s_lpnp;
    logic       s_link;
    logic       s_prx;
    logic       s_ptx;

    assign {s_an_en, s_done, s_state_lvl, s_pdf, s_page, s_resolved, s_manual,
            s_rflt, s_lpan, s_lpnp, s_link, s_prx, s_ptx} = sync_b;

    // event inputs are levels that may last many cycles; take the rising edge
    logic [5:0] ev_prev;
    logic [5:0] ev_rise;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ev_prev <= '0;
        end else begin
            ev_prev <= {s_state_lvl, s_pdf, s_page};
        end
    end
    assign ev_rise = {s_state_lvl, s_pdf, s_page} & ~ev_prev;

    // mode words cross as 3-bit buses; bits may land in different cycles,
    // so a word is taken only after two equal samples (two cycles of latency)
    logic [5:0] mode_prev;
    logic [5:0] mode_stable;
    logic [5:0] next_mode_stable;
    logic [2:0] stable_resolved;
    logic [2:0] stable_manual;

    always_comb begin
        next_mode_stable = mode_stable;
        if ({s_resolved, s_manual} == mode_prev) begin
            next_mode_stable = mode_prev;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_prev   <= '0;
            mode_stable <= '0;
        end else begin
            mode_prev   <= {s_resolved, s_manual};
            mode_stable <= next_mode_stable;
        end
    end
    assign {stable_resolved, stable_manual} = mode_stable;

    ////////////////////////////////////////////////////////////////////////
    // shadow registers at 18h
    logic [15:0] test_reg;
    logic [15:0] ctl_reg;
    logic [15:0] next_test_reg;
    logic [15:0] next_ctl_reg;
    logic        wr_shadow;
    logic        rd_status;

    assign wr_shadow = wr && addr == phy_shadow_pkg::ADDR_SHADOW;
    assign rd_status = rd && addr == phy_shadow_pkg::ADDR_STATUS;

    always_comb begin
        next_test_reg = test_reg;
        next_ctl_reg  = ctl_reg;
        if (wr_shadow && wdata[2:0] == phy_shadow_pkg::SHADOW_TEST) begin
            // select field is fixed at the own code
            next_test_reg = (wdata & phy_shadow_pkg::TST_WMASK)
                          | {13'h0000, phy_shadow_pkg::SHADOW_TEST};
        end
        if (wr_shadow && wdata[2:0] == phy_shadow_pkg::SHADOW_CONTROL) begin
            next_ctl_reg = (ctl_reg & ~phy_shadow_pkg::CTL_ALWAYS_W)
                         | (wdata & phy_shadow_pkg::CTL_ALWAYS_W);
            if (wdata[phy_shadow_pkg::CTL_WEN]) begin
                next_ctl_reg = (next_ctl_reg & ~phy_shadow_pkg::CTL_GATED_W)
                             | (wdata & phy_shadow_pkg::CTL_GATED_W);
            end
            // write enable self-clears; select field holds the own code
            next_ctl_reg[phy_shadow_pkg::CTL_WEN] = 1'b0;
            next_ctl_reg[2:0] = phy_shadow_pkg::SHADOW_CONTROL;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            test_reg <= phy_shadow_pkg::TST_RESET;
            ctl_reg  <= phy_shadow_pkg::CTL_RESET;
        end else begin
            test_reg <= next_test_reg;
            ctl_reg  <= next_ctl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latched-high status flags: 14..11, 7, 5
    logic [5:0] sticky_flag;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sticky
            latch_high_flag u_flag (
                .clock    (clock),
                .rst      (rst),
                .event_in (ev_rise[gi]),
                .clear    (rd_status),
                .flag     (sticky_flag[gi])
            );
        end
    endgenerate

    logic [15:0] status_word;
    logic [2:0]  mode_code;

    always_comb begin
        // negotiation off shows manual mode; in progress shows none
        if (!s_an_en) begin
            mode_code = stable_manual;
        end else if (s_done) begin
            mode_code = stable_resolved;
        end else begin
            mode_code = phy_shadow_pkg::MODE_NONE;
        end
        status_word = '0;
        status_word[phy_shadow_pkg::ST_DONE] = s_done;
        status_word[14:11] = sticky_flag[5:2];
        status_word[phy_shadow_pkg::ST_MODE +: 3] = mode_code;
        status_word[phy_shadow_pkg::ST_PDF]  = sticky_flag[1];
        status_word[phy_shadow_pkg::ST_RFLT] = s_rflt;
        status_word[phy_shadow_pkg::ST_PAGE] = sticky_flag[0];
        status_word[phy_shadow_pkg::ST_LPAN] = s_lpan;
        status_word[phy_shadow_pkg::ST_LPNP] = s_lpnp;
        status_word[phy_shadow_pkg::ST_LINK] = s_link;
        // raw pause result; software checks bit 15 first
        status_word[phy_shadow_pkg::ST_PRX]  = s_prx;
        status_word[phy_shadow_pkg::ST_PTX]  = s_ptx;
    end

    ////////////////////////////////////////////////////////////////////////
    // read path and registered outputs
    logic [15:0] next_rdata;
    logic [2:0]  rsel;

    assign rsel = ctl_reg[phy_shadow_pkg::CTL_RSEL_LO +: 3];

    always_comb begin
        next_rdata = '0;
        if (rd && addr == phy_shadow_pkg::ADDR_SHADOW) begin
            unique case (rsel)
                phy_shadow_pkg::SHADOW_TEST:    next_rdata = test_reg;
                phy_shadow_pkg::SHADOW_CONTROL: next_rdata = ctl_reg;
                default:                    next_rdata = '0;
            endcase
        end else if (rd_status) begin
            next_rdata = status_word;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata             <= '0;
            lineside_loopback <= 1'b0;
            rx_mac_tristate   <= 1'b0;
            same_pair_test    <= 1'b0;
            half_amplitude_tx <= 1'b0;
            count_rx_packets  <= 1'b0;
            force_auto_mdix   <= 1'b0;
            auto_mdix_run     <= 1'b1;
            rx_skew_enable    <= 1'b1;
            other_shadow_wr   <= 1'b0;
            read_shadow       <= phy_shadow_pkg::SHADOW_AUX;
        end else begin
            rdata             <= next_rdata;
            lineside_loopback <= test_reg[phy_shadow_pkg::TST_LOOP];
            rx_mac_tristate   <= test_reg[phy_shadow_pkg::TST_LOOP]
                               & test_reg[phy_shadow_pkg::TST_LOOP_TRI];
            same_pair_test    <= test_reg[phy_shadow_pkg::TST_SAME_PAIR];
            // the analog side applies this only in 10M operation
            half_amplitude_tx <= test_reg[phy_shadow_pkg::TST_HALF_AMP];
            count_rx_packets  <= ctl_reg[phy_shadow_pkg::CTL_PKT_RX];
            force_auto_mdix   <= ctl_reg[phy_shadow_pkg::CTL_MDIX];
            auto_mdix_run     <= s_an_en | ctl_reg[phy_shadow_pkg::CTL_MDIX];
            rx_skew_enable    <= ctl_reg[phy_shadow_pkg::CTL_SKEW];
            other_shadow_wr   <= wr_shadow && wdata[2:0] != phy_shadow_pkg::SHADOW_TEST
                               && wdata[2:0] != phy_shadow_pkg::SHADOW_CONTROL;
            read_shadow       <= rsel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ctl_gated_write: assert property (@(posedge clock) disable iff (rst)
        wr_shadow && wdata[2:0] == phy_shadow_pkg::SHADOW_CONTROL && !wdata[15]
        |=> ctl_reg[11:3] == $past(ctl_reg[11:3]))
        else $error("control bits 11:3 changed without write enable");
    a_ctl_wen_clear: assert property (@(posedge clock) disable iff (rst)
        !ctl_reg[phy_shadow_pkg::CTL_WEN])
        else $error("write enable did not self clear");
    a_ctl_rsel_write: assert property (@(posedge clock) disable iff (rst)
        wr_shadow && wdata[2:0] == phy_shadow_pkg::SHADOW_CONTROL
        |=> ctl_reg[14:12] == $past(wdata[14:12]))
        else $error("read selector not written");
    a_select_field: assert property (@(posedge clock) disable iff (rst)
        test_reg[2:0] == phy_shadow_pkg::SHADOW_TEST
        && ctl_reg[2:0] == phy_shadow_pkg::SHADOW_CONTROL)
        else $error("shadow select field wrong");
    a_tristate_follow: assert property (@(posedge clock) disable iff (rst)
        rx_mac_tristate |-> lineside_loopback)
        else $error("receive pins floated outside loopback");
    a_status_clear: assert property (@(posedge clock) disable iff (rst)
        rd_status && ev_rise == '0 |=> sticky_flag == '0)
        else $error("latched flags not cleared by read");
    a_flag_set: assert property (@(posedge clock) disable iff (rst)
        ev_rise[5] |=> sticky_flag[5] ##1 rdata[14] || !$past(rd_status))
        else $error("state entry flag not latched");
    a_mode_none: assert property (@(posedge clock) disable iff (rst)
        rd_status && s_an_en && !s_done |=> rdata[10:8] == phy_shadow_pkg::MODE_NONE)
        else $error("mode reported before completion");
    a_loop_follow: assert property (@(posedge clock) disable iff (rst)
        ##1 lineside_loopback == $past(test_reg[phy_shadow_pkg::TST_LOOP]))
        else $error("loopback output lags test bit");
    a_same_pair_follow: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> same_pair_test == $past(test_reg[phy_shadow_pkg::TST_SAME_PAIR]))
        else $error("same pair output lags test bit");
    a_half_amp_follow: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> half_amplitude_tx == $past(test_reg[phy_shadow_pkg::TST_HALF_AMP]))
        else $error("half amplitude output lags test bit");
    a_other_strobe: assert property (@(posedge clock) disable iff (rst)
        wr_shadow && wdata[2:0] == phy_shadow_pkg::SHADOW_TEST |=> !other_shadow_wr)
        else $error("test write leaked to other shadows");
    a_pkt_count_follow: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> count_rx_packets == $past(ctl_reg[phy_shadow_pkg::CTL_PKT_RX]))
        else $error("packet count mode lags control bit");
    a_mdix_run: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> auto_mdix_run == ($past(s_an_en) || $past(ctl_reg[phy_shadow_pkg::CTL_MDIX])))
        else $error("crossover run wrong");
    a_skew_follow: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> rx_skew_enable == $past(ctl_reg[phy_shadow_pkg::CTL_SKEW]))
        else $error("skew enable lags control bit");
    a_done_bit: assert property (@(posedge clock) disable iff (rst)
        rd_status |=> rdata[phy_shadow_pkg::ST_DONE] == $past(s_done))
        else $error("completion bit wrong");
    a_mode_manual: assert property (@(posedge clock) disable iff (rst)
        rd_status && !s_an_en |=> rdata[10:8] == $past(stable_manual))
        else $error("manual mode not reported");
    a_read_idle: assert property (@(posedge clock) disable iff (rst)
        !$past(rd) |-> rdata == '0)
        else $error("read data outside its cycle");
endmodule // phy_shadow_regs

/* tb/phy_shadow_regs_test.sv */
`timescale 1ns/1ps
module phy_shadow_regs_test;
    logic        clock, rst, wr, rd;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic        an_enable, an_complete, ev_link_good_check, ev_ack_detect;
    logic        ev_ability_detect, ev_next_page_wait, ev_parallel_fault, ev_page_received;
    logic [2:0]  resolved_common_mode, manual_mode, read_shadow;
    logic        partner_remote_fault, partner_an_able, partner_next_page;
    logic        link_pass, pause_rx, pause_tx, lineside_loopback, rx_mac_tristate;
    logic        same_pair_test, half_amplitude_tx, count_rx_packets, force_auto_mdix;
    logic        auto_mdix_run, rx_skew_enable, other_shadow_wr, s1, s2;
    int          fail_count, checked;

    phy_shadow_regs uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .an_enable(an_enable), .an_complete(an_complete),
        .ev_link_good_check(ev_link_good_check), .ev_ack_detect(ev_ack_detect),
        .ev_ability_detect(ev_ability_detect), .ev_next_page_wait(ev_next_page_wait),
        .ev_parallel_fault(ev_parallel_fault), .ev_page_received(ev_page_received),
        .resolved_common_mode(resolved_common_mode), .manual_mode(manual_mode),
        .partner_remote_fault(partner_remote_fault), .partner_an_able(partner_an_able),
        .partner_next_page(partner_next_page), .link_pass(link_pass), .pause_rx(pause_rx),
        .pause_tx(pause_tx), .lineside_loopback(lineside_loopback),
        .rx_mac_tristate(rx_mac_tristate), .same_pair_test(same_pair_test),
        .half_amplitude_tx(half_amplitude_tx), .count_rx_packets(count_rx_packets),
        .force_auto_mdix(force_auto_mdix), .auto_mdix_run(auto_mdix_run),
        .rx_skew_enable(rx_skew_enable), .other_shadow_wr(other_shadow_wr),
        .read_shadow(read_shadow));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string what);
        check16({15'h0, got}, {15'h0, exp}, what);
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [15:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic reg_read(input logic [4:0] a, output logic [15:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    // controls follow one edge after the register
    task automatic wait_out();
        @(posedge clock);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("counts: checked %0d, failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1;
        check1(rx_skew_enable, 1'b1, "skew at reset");
        check16({13'h0, read_shadow}, 16'h0, "selector at reset");
        check1(lineside_loopback, 1'b0, "loopback at reset");
        reg_write(5'h18, 16'h4007);
        reg_read(5'h18, d);
        check16(d, 16'h4004, "test reset word");
        reg_write(5'h18, 16'h7007);
        reg_read(5'h18, d);
        check16(d, 16'h71e7, "control reset word");
        check16({13'h0, read_shadow}, 16'h7, "selector");
        $display("test reset done");
    endtask

    task automatic t_test_reg();
        logic [15:0] tv [4] = '{16'h881c, 16'h081c, 16'h8004, 16'h000c};
        reg_write(5'h18, 16'h4007);
        foreach (tv[i]) begin
            reg_write(5'h18, tv[i]);
            wait_out();
            check1(lineside_loopback, tv[i][15], "loopback");
            check1(rx_mac_tristate, tv[i][15] & tv[i][11], "tristate");
            check1(same_pair_test, tv[i][4], "same pair");
            check1(half_amplitude_tx, tv[i][3], "half amplitude");
            reg_read(5'h18, d);
            check16(d, tv[i], "test readback");
        end
        $display("test shadow done");
    endtask

    task automatic t_control();
        reg_write(5'h18, 16'h7a07);
        wait_out();
        reg_read(5'h18, d);
        check16(d, 16'h71e7, "gated bits kept");
        check1(rx_skew_enable, 1'b1, "skew kept");
        reg_write(5'h18, 16'hfa07);
        wait_out();
        check1(count_rx_packets, 1'b1, "count rx");
        check1(force_auto_mdix, 1'b1, "force mdix");
        check1(auto_mdix_run, 1'b1, "mdix run forced");
        check1(rx_skew_enable, 1'b0, "skew off");
        reg_read(5'h18, d);
        check16(d, 16'h7a07, "enabled write, wen self clears");
        reg_write(5'h18, 16'h8007);
        wait_out();
        check16({13'h0, read_shadow}, 16'h0, "selector normal");
        check1(auto_mdix_run, 1'b0, "mdix off without negotiation");
        check1(count_rx_packets, 1'b0, "count tx");
        reg_read(5'h18, d);
        check16(d, 16'h0, "normal shadow lives elsewhere");
        $display("test control done");
    endtask

    task automatic t_other();
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
        foreach (codes[i]) begin
            reg_write(5'h18, {13'h1fff, codes[i]});
            #1 s1 = other_shadow_wr;
            wait_out();
            s2 = other_shadow_wr;
            check1(s1 | s2, 1'b1, "other shadow strobe");
            check1(s1 & s2, 1'b0, "strobe one cycle");
        end
        reg_write(5'h18, 16'h4007);
        #1 check1(other_shadow_wr, 1'b0, "no strobe for control");
        reg_read(5'h18, d);
        check16(d, 16'h000c, "test untouched");
        reg_write(5'h05, 16'h0001);
        #1 check1(other_shadow_wr, 1'b0, "no strobe off address");
        reg_read(5'h05, d);
        check16(d, 16'h0, "unmapped read");
        $display("test other codes done");
    endtask

    task automatic t_status();
        @(posedge clock);
        {an_enable, an_complete, resolved_common_mode} <= 5'b11101;
        {partner_remote_fault, partner_an_able, link_pass, pause_rx} <= 4'hf;
        {ev_link_good_check, ev_ability_detect, ev_parallel_fault} <= 3'h7;
        repeat (6) @(posedge clock);
        reg_read(5'h19, d);
        // pause bits are judged here, where bit 15 reads 1
        check16(d, 16'hd5d6, "status first");
        reg_read(5'h19, d);
        check16(d, 16'h8556, "flags cleared by read");
        check1(auto_mdix_run, 1'b1, "mdix with negotiation");
        @(posedge clock);
        {ev_link_good_check, ev_ability_detect, ev_parallel_fault} <= 3'h0;
        {ev_ack_detect, ev_next_page_wait, ev_page_received} <= 3'h7;
        {an_complete, partner_remote_fault, partner_an_able, link_pass, pause_rx} <= 5'h0;
        {partner_next_page, pause_tx} <= 2'h3;
        repeat (6) @(posedge clock);
        reg_read(5'h19, d);
        check16(d, 16'h2829, "status second");
        reg_read(5'h19, d);
        check16(d, 16'h0009, "second clear");
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            {an_enable, an_complete} <= 2'b01;
            manual_mode <= 3'(i);
            resolved_common_mode <= ~3'(i);
            repeat (5) @(posedge clock);
            reg_read(5'h19, d);
            // completion driven high again, so bit 15 reads set
            check16(d, {1'b1, 4'h0, 3'(i), 8'h09}, "manual mode");
        end
        $display("test status done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        // a hang here means a read never returned
        #(25 * 4000);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        fail_count = 0;
        checked = 0;
        {rst, wr, rd, addr, wdata} = {1'b1, 2'b0, 5'h0, 16'h0};
        {an_enable, an_complete, ev_link_good_check, ev_ack_detect} = 4'h0;
        {ev_ability_detect, ev_next_page_wait, ev_parallel_fault, ev_page_received} = 4'h0;
        {resolved_common_mode, manual_mode} = 6'h0;
        {partner_remote_fault, partner_an_able, partner_next_page} = 3'h0;
        {link_pass, pause_rx, pause_tx} = 3'h0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_test_reg();
        t_control();
        t_other();
        t_status();
        tally_and_finish();
    end
endmodule // phy_shadow_regs_test
